// ==== phy_reset_link_cable_diag_regs_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin errCount++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module phy_reset_link_cable_diag_regs_tb;
   import prlcd_pkg::*;
   logic        sys_clk, rst_n, hsel, hwrite, hreadyout, hresp;
   wire  logic  hready;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, peakLoc;
   logic        fullResetPulse, circuitRestartPulse, standbyReq, diagStartPulse, irq;
   logic [3:0]  linkIn, peakNeg;
   logic        diagDone, diagFail, faultFound, faultShort;
   logic [7:0]  faultDist;
   logic [15:0] rdv;
   int          errCount, nChecks;
   // rows: live link inputs, register index, expected read value
   logic [29:0] rows [13] = '{
      {4'h0, IDX_LINK, 16'h05e0}, {4'h0, IDX_FAULT, 16'h0000}, {4'h0, IDX_PEAK_A, 16'h0000},
      {4'h0, IDX_PEAK_B, 16'h0000}, {4'h0, IDX_POLARITY, 16'h0000},
      {4'h0, IDX_RST_CTRL, 16'h0000}, {4'h0, 10'h3ff, 16'h0000}, {4'h8, IDX_LINK, 16'h15e0},
      {4'h4, IDX_LINK, 16'h05e4}, {4'h2, IDX_LINK, 16'h05e2}, {4'h1, IDX_LINK, 16'h05e1},
      {4'hf, IDX_LINK, 16'h15e7}, {4'h0, IDX_LINK, 16'h05e0}};
   // single slave, so its ready is the bus ready
   assign hready = hreadyout;
   prlcd_regs prlcd_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fullResetPulse(fullResetPulse),
      .circuitRestartPulse(circuitRestartPulse), .standbyReq(standbyReq), .linkUp(linkIn[3]),
      .scramblerLock(linkIn[2]), .localRxValid(linkIn[1]), .remoteRxValid(linkIn[0]),
      .diagStartPulse(diagStartPulse), .diagDone(diagDone), .diagFail(diagFail),
      .faultFound(faultFound), .faultShort(faultShort), .faultDist(faultDist),
      .peakLoc(peakLoc), .peakNeg(peakNeg), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", nChecks, errCount);
      if (errCount == 0 && nChecks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   // bounded wait for a ready edge; a hang ends the run
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 40);
      if (hreadyout !== 1'b1) begin errCount++; tally_and_finish(); end
   endtask : wait_rdy
   // one single word transfer, entered just after a rising edge
   task automatic xfer(input logic wr, input logic [9:0] idx, input logic [15:0] wd);
      hsel <= 1'b1; htrans <= 2'b10; hwrite <= wr; haddr <= {20'h0_0000, idx, 2'b00};
      wait_rdy();
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= {16'h0000, wd};
      wait_rdy();
      rdv = hrdata[15:0];
   endtask : xfer
   task automatic rchk(input logic [9:0] idx, input logic [15:0] exp);
      xfer(1'b0, idx, 16'h0000);
      `CHK(rdv, exp)
   endtask : rchk
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      {rst_n, hsel, hwrite, htrans, haddr, hwdata, linkIn, diagDone, diagFail} = '0;
      {faultFound, faultShort, faultDist, peakLoc, peakNeg} = '0;
      hsize = 3'b010; errCount = 0; nChecks = 0;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      // table rows: reset values, unmapped read, live link bits
      foreach (rows[i]) begin
         linkIn <= rows[i][29:26];
         rchk(rows[i][25:16], rows[i][15:0]);
      end
      `CHK(hresp, 1'b0)
      $display("test rows done");
      // link changes latched as an event, masked until enabled, then cleared
      rchk(IDX_IRQ_STAT, 16'h0004);
      `CHK(irq, 1'b0)
      xfer(1'b1, IDX_IRQ_EN, 16'h0007);
      rchk(IDX_IRQ_EN, 16'h0007);
      `CHK(irq, 1'b1)
      xfer(1'b1, IDX_IRQ_CLR, 16'h0007);
      rchk(IDX_IRQ_STAT, 16'h0000);
      `CHK(irq, 1'b0)
      $display("test irq done");
      // measurement with peak three absent so its polarity is masked
      xfer(1'b1, IDX_TDR_CTRL, 16'h8000);
      #1 `CHK(diagStartPulse, 1'b1)
      @(posedge sys_clk);
      diagDone <= 1'b1; faultFound <= 1'b1; faultShort <= 1'b1; faultDist <= 8'h2a;
      peakLoc <= 32'h1100_2233; peakNeg <= 4'hf;
      @(posedge sys_clk);
      diagDone <= 1'b0; faultDist <= 8'h00; peakLoc <= 32'h0000_0000; peakNeg <= 4'h0;
      rchk(IDX_TDR_CTRL, 16'h0002);
      `CHK(irq, 1'b1)
      rchk(IDX_FAULT, 16'h032a);
      rchk(IDX_PEAK_A, 16'h2233);
      rchk(IDX_PEAK_B, 16'h1100);
      rchk(IDX_POLARITY, 16'h5800);
      xfer(1'b1, IDX_FAULT, 16'hffff);
      rchk(IDX_FAULT, 16'h032a);
      // a stray done while idle is ignored, then a failing run
      diagDone <= 1'b1; diagFail <= 1'b1; faultDist <= 8'h55;
      @(posedge sys_clk);
      diagDone <= 1'b0; diagFail <= 1'b0;
      rchk(IDX_FAULT, 16'h032a);
      xfer(1'b1, IDX_TDR_CTRL, 16'h8000);
      rchk(IDX_FAULT, 16'h0000);
      diagDone <= 1'b1; diagFail <= 1'b1; faultFound <= 1'b0; faultShort <= 1'b0;
      @(posedge sys_clk);
      diagDone <= 1'b0; diagFail <= 1'b0;
      rchk(IDX_TDR_CTRL, 16'h0003);
      rchk(IDX_IRQ_STAT, 16'h0003);
      rchk(IDX_FAULT, 16'h0055);
      $display("test diag done");
      // standby level, restart pulse keeps registers
      xfer(1'b1, IDX_RST_CTRL, 16'h0080);
      rchk(IDX_RST_CTRL, 16'h0080);
      `CHK(standbyReq, 1'b1)
      xfer(1'b1, IDX_RST_CTRL, 16'h4080);
      #1 `CHK(circuitRestartPulse, 1'b1)
      @(posedge sys_clk);
      #1 `CHK(circuitRestartPulse, 1'b0)
      @(posedge sys_clk);
      rchk(IDX_RST_CTRL, 16'h0080);
      // full reset clears standby and results, bit reads back clear
      xfer(1'b1, IDX_RST_CTRL, 16'h8180);
      #1 `CHK(fullResetPulse, 1'b1)
      @(posedge sys_clk);
      rchk(IDX_RST_CTRL, 16'h0000);
      rchk(IDX_FAULT, 16'h0000);
      `CHK(standbyReq, 1'b0)
      `CHK(irq, 1'b0)
      $display("test control done");
      // pin reset in mid-run
      xfer(1'b1, IDX_RST_CTRL, 16'h0080);
      rchk(IDX_RST_CTRL, 16'h0080);
      rst_n <= 1'b0;
      @(posedge sys_clk);
      #1 `CHK(standbyReq, 1'b0)
      `CHK(hreadyout, 1'b1)
      @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rchk(IDX_RST_CTRL, 16'h0000);
      $display("test pin reset done");
      tally_and_finish();
   end
endmodule : phy_reset_link_cable_diag_regs_tb
`default_nettype wire

// ==== prlcd_ahb_slave.sv ====
`timescale 1ns/100ps
`default_nettype none
module prlcd_ahb_slave (
   // clock and reset
   input  wire logic                          sys_clk,
   input  wire logic                          rst_n,
   // ahb-lite side
   input  wire logic                          hsel,
   input  wire logic [prlcd_pkg::ADDR_W-1:0]  haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [prlcd_pkg::DATA_W-1:0]  hwdata,
   input  wire logic                          hready,
   output logic                               hreadyout,
   output logic [prlcd_pkg::DATA_W-1:0]       hrdata,
   // register side
   output logic                               wrStb,
   output logic                               rdStb,
   output logic [prlcd_pkg::IDX_W-1:0]        regIdx,
   output logic [prlcd_pkg::REG_W-1:0]        wrData,
   input  wire logic [prlcd_pkg::REG_W-1:0]   rdValue
);
   import prlcd_pkg::*;

   prlcd_bus_state_type     state_q;
   prlcd_bus_state_type     state_d;
   logic [IDX_W-1:0]        idx_q;
   logic [DATA_W-1:0]       hrdata_q;
   wire                     accept;

   // address phase taken only for nonseq or seq with the bus ready
   assign accept = hsel && hready && htrans[1];

   // reads take one wait cycle so read data come from a flop
   always_comb begin
      case (state_q)
         BUS_RWAIT: state_d = BUS_RDATA;
         BUS_IDLE, BUS_WDATA, BUS_RDATA: begin
            if (accept) begin
               state_d = hwrite ? BUS_WDATA : BUS_RWAIT;
            end else begin
               state_d = BUS_IDLE;
            end
         end
         default: state_d = BUS_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= BUS_IDLE;
         idx_q   <= '0;
      end else begin
         state_q <= state_d;
         if (accept) idx_q <= haddr[IDX_LSB +: IDX_W];
      end
   end

   // read word latched in the wait cycle, upper half reads zero
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) hrdata_q <= '0;
      else if (rdStb) hrdata_q <= {REG_ZERO, rdValue};
   end

   assign hreadyout = (state_q != BUS_RWAIT);
   assign wrStb     = (state_q == BUS_WDATA);
   assign rdStb     = (state_q == BUS_RWAIT);
   assign regIdx    = idx_q;
   assign wrData    = hwdata[REG_W-1:0];
   assign hrdata    = hrdata_q;
endmodule : prlcd_ahb_slave
`default_nettype wire

// ==== prlcd_irq.sv ====
`timescale 1ns/100ps
`default_nettype none
module prlcd_irq (
   // clock and reset
   input  wire logic                         sys_clk,
   input  wire logic                         rst_n,
   input  wire logic                         syncClr,
   // events and software access
   input  wire logic [prlcd_pkg::EVT_W-1:0]  evt,
   input  wire logic                         enWr,
   input  wire logic                         clrWr,
   input  wire logic [prlcd_pkg::EVT_W-1:0]  wrBits,
   // state
   output logic [prlcd_pkg::EVT_W-1:0]       status,
   output logic [prlcd_pkg::EVT_W-1:0]       enable,
   output logic                              irq
);
   import prlcd_pkg::*;

   logic [EVT_W-1:0] status_q;
   logic [EVT_W-1:0] enable_q;

   // sticky bits: a new event wins over a clear in the same cycle
   for (genvar i = 0; i < EVT_W; i++) begin : g_bit
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) status_q[i] <= 1'b0;
         else if (evt[i]) status_q[i] <= 1'b1;
         else if (syncClr || (clrWr && wrBits[i])) status_q[i] <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) enable_q <= '0;
      else if (syncClr) enable_q <= '0;
      else if (enWr) enable_q <= wrBits;
   end

   assign status = status_q;
   assign enable = enable_q;
   assign irq    = |(status_q & enable_q);
endmodule : prlcd_irq
`default_nettype wire

// ==== prlcd_pkg.sv ====
`default_nettype none
package prlcd_pkg;
   // bus geometry
   localparam int          ADDR_W     = 32;
   localparam int          DATA_W     = 32;
   localparam int          REG_W      = 16;
   localparam int          IDX_W      = 10;
   localparam int          IDX_LSB    = 2;
   // register indices, byte address is four times the index
   localparam logic [9:0]  IDX_TDR_CTRL  = 10'h01e;
   localparam logic [9:0]  IDX_RST_CTRL  = 10'h01f;
   localparam logic [9:0]  IDX_LINK      = 10'h133;
   localparam logic [9:0]  IDX_FAULT     = 10'h16b;
   localparam logic [9:0]  IDX_PEAK_A    = 10'h180;
   localparam logic [9:0]  IDX_PEAK_B    = 10'h181;
   localparam logic [9:0]  IDX_POLARITY  = 10'h18a;
   localparam logic [9:0]  IDX_IRQ_STAT  = 10'h1f0;
   localparam logic [9:0]  IDX_IRQ_EN    = 10'h1f1;
   localparam logic [9:0]  IDX_IRQ_CLR   = 10'h1f2;
   // reset and standby control fields
   localparam int          RST_FULL_BIT    = 15;
   localparam int          RST_RESTART_BIT = 14;
   localparam int          RST_STANDBY_BIT = 7;
   localparam logic [15:0] RST_RSVD_MASK   = 16'h3f7f;
   // diagnostic control fields
   localparam int          TDR_START_BIT = 15;
   // link state fields
   localparam logic [8:0]  LINK_RSVD_RST = 9'h0bc;
   // fault distance step in decimetres, peak code offset
   localparam int          FAULT_STEP_DM = 15;
   localparam int          PEAK_OFFSET   = 4;
   localparam int          PEAK_N        = 4;
   localparam int          PEAK_W        = 8;
   // interrupt event positions
   localparam int          EVT_W    = 3;
   localparam int          EVT_DONE = 0;
   localparam int          EVT_FAIL = 1;
   localparam int          EVT_LINK = 2;
   localparam logic [15:0] REG_ZERO = 16'h0000;
   // bus slave states
   typedef enum logic [1:0] {
      BUS_IDLE  = 2'b00,
      BUS_WDATA = 2'b01,
      BUS_RWAIT = 2'b10,
      BUS_RDATA = 2'b11
   } prlcd_bus_state_type;
endpackage : prlcd_pkg
`default_nettype wire

// ==== prlcd_regs.sv ====
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module prlcd_regs (
   // clock and reset
   input  wire logic                          sys_clk,
   input  wire logic                          rst_n,
   // ahb-lite slave
   input  wire logic                          hsel,
   input  wire logic [prlcd_pkg::ADDR_W-1:0]  haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic [prlcd_pkg::DATA_W-1:0]  hwdata,
   input  wire logic                          hready,
   output logic                               hreadyout,
   output logic                               hresp,
   output logic [prlcd_pkg::DATA_W-1:0]       hrdata,
   // transceiver control
   output logic                               fullResetPulse,
   output logic                               circuitRestartPulse,
   output logic                               standbyReq,
   // live link state
   input  wire logic                          linkUp,
   input  wire logic                          scramblerLock,
   input  wire logic                          localRxValid,
   input  wire logic                          remoteRxValid,
   // cable diagnostic engine
   output logic                               diagStartPulse,
   input  wire logic                          diagDone,
   input  wire logic                          diagFail,
   input  wire logic                          faultFound,
   input  wire logic                          faultShort,
   input  wire logic [7:0]                    faultDist,
   input  wire logic [31:0]                   peakLoc,
   input  wire logic [3:0]                    peakNeg,
   // interrupt
   output logic                               irq
);
   import prlcd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   function automatic logic idxIs(input logic [IDX_W-1:0] a,
                                  input logic [IDX_W-1:0] b);
      return a == b;
   endfunction : idxIs

   logic                wrStb;
   logic                rdStb;
   logic [IDX_W-1:0]    regIdx;
   logic [REG_W-1:0]    wrData;
   logic [REG_W-1:0]    rdValue;

   logic                fullRst_q;
   logic                restart_q;
   logic                standby_q;
   logic [REG_W-1:0]    rstRsvd_q;
   logic [3:0]          link_q;
   logic                start_q;
   logic                busy_q;
   logic                done_q;
   logic                fail_q;
   logic                faultFound_q;
   logic                faultShort_q;
   logic [7:0]          faultDist_q;
   logic [31:0]         peakLoc_q;
   logic [3:0]          peakNeg_q;
   logic [PEAK_N-1:0]   polRead;
   logic [EVT_W-1:0]    evt;
   logic [EVT_W-1:0]    irqStatus;
   logic [EVT_W-1:0]    irqEnable;

   wire                 ctrlWr;
   wire                 tdrWr;
   wire                 irqEnWr;
   wire                 irqClrWr;
   wire                 startWr;
   wire                 diagAccept;
   wire [REG_W-1:0]     rstWord;
   wire [REG_W-1:0]     tdrWord;
   wire [REG_W-1:0]     linkWord;
   wire [REG_W-1:0]     faultWord;
   wire [REG_W-1:0]     polWord;
   wire [REG_W-1:0]     irqStatWord;
   wire [REG_W-1:0]     irqEnWord;

   ////////////////////////////////////////////////////////////////////////////
   // bus slave

   prlcd_ahb_slave u_bus (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hrdata    (hrdata),
      .wrStb     (wrStb),
      .rdStb     (rdStb),
      .regIdx    (regIdx),
      .wrData    (wrData),
      .rdValue   (rdValue)
   );

   // always okay; only word transfers are expected, hsize is not checked
   assign hresp = 1'b0;

   // write decode, writes to read-only indices fall through unused
   assign ctrlWr   = wrStb && idxIs(regIdx, IDX_RST_CTRL);
   assign tdrWr    = wrStb && idxIs(regIdx, IDX_TDR_CTRL);
   assign irqEnWr  = wrStb && idxIs(regIdx, IDX_IRQ_EN);
   assign irqClrWr = wrStb && idxIs(regIdx, IDX_IRQ_CLR);
   assign startWr  = tdrWr && wrData[TDR_START_BIT] && !fullRst_q;

   ////////////////////////////////////////////////////////////////////////////
   // reset and standby control

   // full reset lasts one cycle and then clears the bank except the live link bits and a link event in that cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) fullRst_q <= 1'b0;
      else fullRst_q <= ctrlWr && wrData[RST_FULL_BIT];
   end

   // restart leaves every register alone, only pulses outward; full reset wins
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) restart_q <= 1'b0;
      else restart_q <= ctrlWr && wrData[RST_RESTART_BIT] && !wrData[RST_FULL_BIT]
                        && !fullRst_q;
   end

   // standby and reserved bits are plain storage
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         standby_q <= 1'b0;
         rstRsvd_q <= REG_ZERO;
      end else if (fullRst_q) begin
         standby_q <= 1'b0;
         rstRsvd_q <= REG_ZERO;
      end else if (ctrlWr) begin
         standby_q <= wrData[RST_STANDBY_BIT];
         rstRsvd_q <= wrData & RST_RSVD_MASK;
      end
   end

   assign fullResetPulse      = fullRst_q;
   assign circuitRestartPulse = restart_q;
   assign standbyReq          = standby_q;

   ////////////////////////////////////////////////////////////////////////////
   // link state

   // sampled every cycle, never latched
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) link_q <= 4'h0;
      else link_q <= {linkUp, scramblerLock, localRxValid, remoteRxValid};
   end

   ////////////////////////////////////////////////////////////////////////////
   // cable diagnostic control and results

   // a done only counts while running; full reset beats a run finishing with it
   assign diagAccept = diagDone && busy_q && !fullRst_q;

   // start self-clears after its one-cycle pulse
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         start_q <= 1'b0;
         busy_q  <= 1'b0;
      end else begin
         start_q <= startWr;
         if (fullRst_q) busy_q <= 1'b0;
         else if (startWr) busy_q <= 1'b1;
         else if (diagDone) busy_q <= 1'b0;
      end
   end

   // flags: the engine setting wins over a clear by a new start
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_q <= 1'b0;
         fail_q <= 1'b0;
      end else begin
         if (diagAccept) done_q <= 1'b1;
         else if (startWr || fullRst_q) done_q <= 1'b0;
         if (diagAccept && diagFail) fail_q <= 1'b1;
         else if (startWr || fullRst_q) fail_q <= 1'b0;
      end
   end

   // results captured on completion, held until next start or full reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         faultFound_q <= 1'b0;
         faultShort_q <= 1'b0;
         faultDist_q  <= 8'h00;
         peakLoc_q    <= 32'h0000_0000;
         peakNeg_q    <= 4'h0;
      end else if (diagAccept) begin
         faultFound_q <= faultFound;
         faultShort_q <= faultShort;
         faultDist_q  <= faultDist;
         peakLoc_q    <= peakLoc;
         peakNeg_q    <= peakNeg;
      end else if (startWr || fullRst_q) begin
         faultFound_q <= 1'b0;
         faultShort_q <= 1'b0;
         faultDist_q  <= 8'h00;
         peakLoc_q    <= 32'h0000_0000;
         peakNeg_q    <= 4'h0;
      end
   end

   assign diagStartPulse = start_q;

   // polarity is hidden where the peak code is zero, so no stale sign reads
   for (genvar p = 0; p < PEAK_N; p++) begin : g_peak
      assign polRead[p] = peakNeg_q[p] && (|peakLoc_q[p*PEAK_W +: PEAK_W]);
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupts

   assign evt[EVT_DONE] = diagAccept;
   assign evt[EVT_FAIL] = diagAccept && diagFail;
   assign evt[EVT_LINK] = (link_q[3] != linkUp);

   prlcd_irq u_irq (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .syncClr (fullRst_q),
      .evt     (evt),
      .enWr    (irqEnWr),
      .clrWr   (irqClrWr),
      .wrBits  (wrData[EVT_W-1:0]),
      .status  (irqStatus),
      .enable  (irqEnable),
      .irq     (irq)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read words and read mux

   assign rstWord   = rstRsvd_q | {fullRst_q, restart_q, 6'h00, standby_q, 7'h00};
   assign tdrWord   = {start_q, 13'h0000, done_q, fail_q};
   assign linkWord  = {3'h0, link_q[3], LINK_RSVD_RST, link_q[2:0]};
   assign faultWord = {6'h00, faultFound_q, faultShort_q, faultDist_q};
   assign polWord   = {1'b0, polRead, 11'h000};
   assign irqStatWord = {13'h0000, irqStatus};
   assign irqEnWord   = {13'h0000, irqEnable};

   // unmapped and write-only indices read zero
   assign rdValue =
      idxIs(regIdx, IDX_RST_CTRL) ? rstWord     :
      idxIs(regIdx, IDX_TDR_CTRL) ? tdrWord     :
      idxIs(regIdx, IDX_LINK)     ? linkWord    :
      idxIs(regIdx, IDX_FAULT)    ? faultWord   :
      idxIs(regIdx, IDX_PEAK_A)   ? peakLoc_q[15:0] :
      idxIs(regIdx, IDX_PEAK_B)   ? peakLoc_q[31:16] :
      idxIs(regIdx, IDX_POLARITY) ? polWord     :
      idxIs(regIdx, IDX_IRQ_STAT) ? irqStatWord :
      idxIs(regIdx, IDX_IRQ_EN)   ? irqEnWord   : REG_ZERO;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   AST_FULL_RESET_ONE_CYCLE: assert property (
      (ctrlWr && wrData[RST_FULL_BIT]) |=> fullResetPulse ##1 !fullResetPulse)
      else $error("full reset did not pulse for one cycle");

   AST_FULL_RESET_CLEARS_BANK: assert property (
      fullRst_q |=> (!standbyReq && !done_q && faultDist_q == 8'h00))
      else $error("full reset left bank state behind");

   AST_RESTART_KEEPS_REGS: assert property (
      (ctrlWr && wrData[RST_RESTART_BIT] && !wrData[RST_FULL_BIT] && !fullRst_q)
      |=> circuitRestartPulse && standbyReq == $past(wrData[RST_STANDBY_BIT])
      ##1 !circuitRestartPulse)
      else $error("restart pulse wrong or registers disturbed");

   AST_STANDBY_HOLDS: assert property (
      (!ctrlWr && !fullRst_q) |=> $stable(standbyReq))
      else $error("standby changed without a write");

   AST_LINK_LIVE: assert property (
      ##1 link_q == $past({linkUp, scramblerLock, localRxValid, remoteRxValid}))
      else $error("link status not following inputs");

   AST_RESULT_CAPTURE: assert property (
      diagAccept |=> (faultWord[9:0] == $past({faultFound, faultShort, faultDist})))
      else $error("fault result not captured on completion");

   AST_PEAK_CAPTURE: assert property (
      diagAccept |=> (peakLoc_q == $past(peakLoc)))
      else $error("peak locations not captured on completion");

   AST_POLARITY_GATED: assert property (
      (peakLoc_q[7:0] == 8'h00) |-> !polWord[11])
      else $error("peak one polarity shown with zero location");

   AST_START_PULSE: assert property (
      startWr |=> diagStartPulse && busy_q ##1 !diagStartPulse)
      else $error("start did not pulse and self clear");

   AST_DONE_FLAG: assert property (
      (diagAccept && diagFail) |=> (done_q && fail_q && tdrWord[1:0] == 2'b11))
      else $error("done or fail flag not set");

   AST_RO_IGNORED: assert property (
      (wrStb && idxIs(regIdx, IDX_FAULT) && !diagAccept && !startWr && !fullRst_q)
      |=> $stable(faultWord))
      else $error("write changed a read-only register");

   AST_RESULTS_HOLD: assert property (
      (!diagAccept && !startWr && !fullRst_q) |=> $stable(peakLoc_q) && $stable(faultDist_q))
      else $error("results changed without a measurement");

   AST_READ_WAIT: assert property (
      rdStb |-> !hreadyout ##1 (hreadyout && hrdata[15:0] == $past(rdValue)))
      else $error("read data phase malformed");

   COV_MEASURE: cover property (startWr ##[1:1000] diagAccept);
   COV_FULL_RESET: cover property (fullRst_q);
   COV_IRQ_RISE: cover property (!irq ##1 irq);
   COV_FAIL: cover property (diagAccept && diagFail);

endmodule : prlcd_regs
`default_nettype wire
